// ==== hdl/tea_pkg.sv ====
// Constants for the TLB entry access registers: addresses, field positions,
// page size and protection encodings, and the page size compare mask.
// Assumes a 32-bit register port with byte addresses and one core clock.
package tea_pkg;

	localparam logic [31:0] I_LOWER_ADDR = 32'hc00000a0;
	localparam logic [31:0] I_UPPER_ADDR = 32'hc00000a4;
	localparam logic [31:0] D_LOWER_ADDR = 32'hc00000b0;
	localparam logic [31:0] D_UPPER_ADDR = 32'hc00000b4;

	localparam int TLB_ENTRIES = 32;
	localparam int NUM_SIDES   = 2;

	// Upper register layout.
	localparam int VPN_MSB  = 31;
	localparam int VPN_LSB  = 10;
	localparam int RSVD_MSB = 9;
	localparam int RSVD_LSB = 8;
	localparam int TAG_MSB  = 7;
	localparam int TAG_LSB  = 0;

	// Lower register layout.
	localparam int PPN_HI_MSB = 31;
	localparam int PPN_HI_LSB = 12;
	localparam int PSIZE_MSB  = 11;
	localparam int PSIZE_LSB  = 10;
	localparam int SHARED_BIT = 9;
	localparam int PROT_MSB   = 8;
	localparam int PROT_LSB   = 6;
	localparam int DIRTY_BIT  = 5;
	localparam int PVALID_BIT = 4;
	localparam int CACHE_BIT  = 3;
	localparam int PPN_LO_MSB = 2;
	localparam int PPN_LO_LSB = 1;
	localparam int EVALID_BIT = 0;

	localparam logic [31:0] UPPER_RESET = 32'h00000000;
	localparam logic [31:0] LOWER_RESET = 32'h00000000;

	localparam logic [1:0] PSIZE_4K   = 2'h0;
	localparam logic [1:0] PSIZE_128K = 2'h1;
	localparam logic [1:0] PSIZE_1K   = 2'h2;
	localparam logic [1:0] PSIZE_4M   = 2'h3;

	localparam logic [2:0] PROT_PRIV_R    = 3'h0;
	localparam logic [2:0] PROT_ALL_R     = 3'h2;
	localparam logic [2:0] PROT_PRIV_RW   = 3'h4;
	localparam logic [2:0] PROT_PRIV_RW_U = 3'h6;
	localparam logic [2:0] PROT_ALL_RW    = 3'h7;

	// Virtual page number bits that take part in the compare for a page size.
	function automatic logic [21:0] tea_size_mask(input logic [1:0] psize);
		case (psize)
			PSIZE_1K:   tea_size_mask = 22'h3fffff;
			PSIZE_4K:   tea_size_mask = 22'h3ffffc;
			PSIZE_128K: tea_size_mask = 22'h3fff80;
			default:    tea_size_mask = 22'h3ff000;
		endcase
	endfunction : tea_size_mask

endpackage : tea_pkg

// ==== hdl/tea_tlb_store.sv ====
// Fully associative translation store for one side, with FIFO replacement.
// Assumes an already synchronised reset and a power of two entry count.
`timescale 1ns/1ps

module tea_tlb_store import tea_pkg::*; #(
	parameter int ENTRIES = TLB_ENTRIES
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        repl,
	input  wire logic [31:0] new_upper,
	input  wire logic [31:0] new_lower,
	input  wire logic [31:0] key,
	output logic             hit,
	output logic [31:0]      hit_lower
);

	localparam int PW = $clog2(ENTRIES);

	logic [31:0]         up_mem [ENTRIES];
	logic [31:0]         lo_mem [ENTRIES];
	logic [ENTRIES-1:0]  vld_reg;
	logic [PW-1:0]       ptr_reg;
	logic [ENTRIES-1:0]  match;

	genvar e;
	generate
		for (e = 0; e < ENTRIES; e++) begin : g_cmp
			wire logic vpn_eq = ((up_mem[e][VPN_MSB:VPN_LSB] ^ key[VPN_MSB:VPN_LSB])
				& tea_size_mask(lo_mem[e][PSIZE_MSB:PSIZE_LSB])) == 22'h000000; //RQ9 RQ10
			wire logic tag_eq = lo_mem[e][SHARED_BIT] ||
				(up_mem[e][TAG_MSB:TAG_LSB] == key[TAG_MSB:TAG_LSB]); //RQ11
			assign match[e] = vld_reg[e] & vpn_eq & tag_eq;
		end
	endgenerate

	// Lowest matching entry wins, so a duplicate mapping stays deterministic.
	always_comb begin
		hit = 1'b0;
		hit_lower = 32'h00000000;
		for (int i = ENTRIES - 1; i >= 0; i--) begin
			if (match[i]) begin
				hit = 1'b1;
				hit_lower = lo_mem[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vld_reg <= '0;
			ptr_reg <= '0;
		end else if (repl) begin
			vld_reg[ptr_reg] <= 1'b1; //RQ6
			ptr_reg <= PW'(ptr_reg + 1'b1);
		end
	end

	always_ff @(posedge clk) begin
		if (repl) begin
			up_mem[ptr_reg] <= new_upper; //RQ6
			lo_mem[ptr_reg] <= new_lower;
		end
	end

endmodule : tea_tlb_store

// ==== hdl/tea_regs.sv ====
// Instruction and data page table entry registers with TLB replace and lookup.
// Assumes a one-cycle strobe register port and fault pulses from core logic.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps

// How it works
// RQ1 - Faults load page number and tag upward
// RQ2 - Upper bits 31..10 hold page number
// RQ3 - Upper bits 9..8 read as zero
// RQ4 - Upper bits 7..0 hold process tag
// RQ5 - Whole-word writes only, byte reads allowed
// RQ6 - Lower write replaces a TLB entry
// RQ7 - Lower read performs lookup, returns entry
// RQ8 - Lower bits 31..12 hold physical page
// RQ9 - Size codes 00,01,11 mean 4K,128K,4M
// RQ10 - Size code 10 means 1K page
// RQ11 - Shared bit skips process tag compare
// RQ12 - Protection 111 grants everything everywhere
// RQ13 - Other protection codes decoded, three prohibited
// RQ14 - Bit 5 is the dirty flag
// RQ15 - Bit 4 is the page valid flag
// RQ16 - Bit 3 is the cacheable flag
// RQ17 - Cacheable bit honoured only when enabled
// RQ18 - Disabled: first space per control, second never
// RQ19 - Bits 2..1 carry physical bits 11..10
// RQ20 - Bit 0 reports lookup hit on read
// RQ21 - Size 11..10, shared 9, protection 8..6
// RQ22 - Instruction and data pairs stay independent
module tea_regs import tea_pkg::*; #(
	parameter int ENTRIES = TLB_ENTRIES
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic [31:0] bus_addr,
	input  wire logic [31:0] bus_wdata,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic        bus_rd_byte,
	output logic      [31:0] bus_rdata,
	input  wire logic        i_fault,
	input  wire logic [31:0] i_fault_addr,
	input  wire logic        d_fault,
	input  wire logic [31:0] d_fault_addr,
	input  wire logic [7:0]  cur_process_tag,
	input  wire logic        cacheable_bit_enable,
	input  wire logic        cache_ctrl_on,
	input  wire logic        space_su1,
	output logic             i_lookup_hit,
	output logic             i_page_cacheable,
	output logic             i_priv_rd,
	output logic             i_priv_wr,
	output logic             i_user_rd,
	output logic             i_user_wr,
	output logic             i_prot_bad,
	output logic             d_lookup_hit,
	output logic             d_page_cacheable,
	output logic             d_priv_rd,
	output logic             d_priv_wr,
	output logic             d_user_rd,
	output logic             d_user_wr,
	output logic             d_prot_bad
);

	// Full aligned word match; misaligned writes never hit.
	function automatic logic word_at(input logic [31:0] a, input logic [31:0] base);
		word_at = (a == base);
	endfunction : word_at

	// Any byte of the word matches, for byte-wide reads.
	function automatic logic lane_at(input logic [31:0] a, input logic [31:0] base);
		lane_at = (a[31:2] == base[31:2]);
	endfunction : lane_at

	// Permission vector: priv read, priv write, user read, user write, prohibited.
	function automatic logic [4:0] prot_perm(input logic [2:0] prot);
		case (prot)
			PROT_PRIV_R:    prot_perm = 5'h10;
			PROT_ALL_R:     prot_perm = 5'h14;
			PROT_PRIV_RW:   prot_perm = 5'h18;
			PROT_PRIV_RW_U: prot_perm = 5'h1c;
			PROT_ALL_RW:    prot_perm = 5'h1e;
			default:        prot_perm = 5'h01;
		endcase
	endfunction : prot_perm

	logic              rst_meta_reg;
	logic              rst_reg;
	logic [31:0]       upper_reg [NUM_SIDES];
	logic [31:0]       upper_next [NUM_SIDES];
	logic [31:0]       lower_reg [NUM_SIDES];
	logic [31:0]       lower_next [NUM_SIDES];
	logic [NUM_SIDES-1:0] hit_reg;
	logic [NUM_SIDES-1:0] hit_next;
	logic [NUM_SIDES-1:0] cache_reg;
	logic [NUM_SIDES-1:0] cache_next;
	logic [4:0]        perm_reg [NUM_SIDES];
	logic [4:0]        perm_next [NUM_SIDES];
	logic [NUM_SIDES-1:0] fault_v;
	logic [31:0]       fault_addr_v [NUM_SIDES];
	logic [NUM_SIDES-1:0] rd_lo;
	logic [NUM_SIDES-1:0] rd_up;
	logic [NUM_SIDES-1:0] wr_lo;
	logic [31:0]       look_word [NUM_SIDES];
	logic [31:0]       rdata_reg;
	logic [31:0]       rdata_next;
	logic [31:0]       rd_word;

	// Reset is released through two flops so every flop leaves reset together.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_reg <= 1'b0;
			rst_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_reg <= rst_meta_reg;
		end
	end

	assign fault_v[0]      = i_fault;
	assign fault_v[1]      = d_fault;
	assign fault_addr_v[0] = i_fault_addr;
	assign fault_addr_v[1] = d_fault_addr;

	genvar s;
	generate
		for (s = 0; s < NUM_SIDES; s++) begin : g_side
			localparam logic [31:0] LO_ADDR = (s == 0) ? I_LOWER_ADDR : D_LOWER_ADDR;
			localparam logic [31:0] UP_ADDR = (s == 0) ? I_UPPER_ADDR : D_UPPER_ADDR;

			wire logic        wr_up = bus_wr & word_at(bus_addr, UP_ADDR); //RQ5 RQ22
			wire logic        st_hit;
			wire logic [31:0] st_lower;
			wire logic [31:0] fault_word;
			wire logic [31:0] wr_up_word;
			wire logic        c_bit;

			assign wr_lo[s] = bus_wr & word_at(bus_addr, LO_ADDR); //RQ5 RQ22
			assign rd_lo[s] = bus_rd & lane_at(bus_addr, LO_ADDR);
			assign rd_up[s] = bus_rd & lane_at(bus_addr, UP_ADDR);

			// The store gets the current upper contents and the word being written.
			tea_tlb_store #(
				.ENTRIES (ENTRIES)
			) u_store (
				.clk       (core_clk),
				.rst_n     (rst_reg),
				.repl      (wr_lo[s]), //RQ6
				.new_upper (upper_reg[s]),
				.new_lower (bus_wdata),
				.key       (upper_reg[s]),
				.hit       (st_hit),
				.hit_lower (st_lower)
			);

			// A miss keeps the old attributes but clears the entry valid bit.
			assign look_word[s] = st_hit ? {st_lower[31:1], 1'b1} //RQ7 RQ20
				: {lower_reg[s][31:1], 1'b0};

			assign fault_word = {fault_addr_v[s][VPN_MSB:VPN_LSB], 2'b00, cur_process_tag}; //RQ1
			assign wr_up_word = {bus_wdata[VPN_MSB:VPN_LSB], 2'b00, //RQ2 RQ3
				bus_wdata[TAG_MSB:TAG_LSB]}; //RQ4

			// A fault in the same cycle as a software write wins, so it is never lost.
			assign upper_next[s] = fault_v[s] ? fault_word
				: wr_up ? wr_up_word : upper_reg[s];
			assign lower_next[s] = wr_lo[s] ? bus_wdata //RQ6 RQ8 RQ14 RQ15 RQ19 RQ21
				: rd_lo[s] ? look_word[s] : lower_reg[s];

			assign c_bit = look_word[s][CACHE_BIT]; //RQ16
			assign hit_next[s]   = rd_lo[s] ? st_hit : hit_reg[s];
			assign cache_next[s] = !rd_lo[s] ? cache_reg[s]
				: cacheable_bit_enable ? c_bit //RQ17
				: (!space_su1 & cache_ctrl_on); //RQ18
			assign perm_next[s]  = rd_lo[s] ? prot_perm(look_word[s][PROT_MSB:PROT_LSB]) //RQ12 RQ13
				: perm_reg[s];

			always_ff @(posedge core_clk or negedge rst_reg) begin
				if (!rst_reg) begin
					upper_reg[s] <= UPPER_RESET;
					lower_reg[s] <= LOWER_RESET;
					hit_reg[s]   <= 1'b0;
					cache_reg[s] <= 1'b0;
					perm_reg[s]  <= 5'h00;
				end else begin
					upper_reg[s] <= upper_next[s];
					lower_reg[s] <= lower_next[s];
					hit_reg[s]   <= hit_next[s];
					cache_reg[s] <= cache_next[s];
					perm_reg[s]  <= perm_next[s];
				end
			end
		end
	endgenerate

	// Lower reads return the lookup result itself, not the stale register.
	assign rd_word = rd_lo[0] ? look_word[0]
		: rd_lo[1] ? look_word[1]
		: rd_up[0] ? upper_reg[0]
		: rd_up[1] ? upper_reg[1] : 32'h00000000;

	// A byte read places the addressed byte in bits 7..0.
	assign rdata_next = !bus_rd ? 32'h00000000 //RQ5
		: bus_rd_byte ? {24'h000000, 8'(rd_word >> {bus_addr[1:0], 3'b000})}
		: rd_word;

	always_ff @(posedge core_clk or negedge rst_reg) begin
		if (!rst_reg) begin
			rdata_reg <= 32'h00000000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign bus_rdata        = rdata_reg;
	assign i_lookup_hit     = hit_reg[0];
	assign i_page_cacheable = cache_reg[0];
	assign i_priv_rd        = perm_reg[0][4];
	assign i_priv_wr        = perm_reg[0][3];
	assign i_user_rd        = perm_reg[0][2];
	assign i_user_wr        = perm_reg[0][1];
	assign i_prot_bad       = perm_reg[0][0];
	assign d_lookup_hit     = hit_reg[1];
	assign d_page_cacheable = cache_reg[1];
	assign d_priv_rd        = perm_reg[1][4];
	assign d_priv_wr        = perm_reg[1][3];
	assign d_user_rd        = perm_reg[1][2];
	assign d_user_wr        = perm_reg[1][1];
	assign d_prot_bad       = perm_reg[1][0];

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_reg);

	sequence s_repl_i;
		bus_wr && bus_addr == I_LOWER_ADDR && !bus_rd && !i_fault;
	endsequence

	sequence s_look_i;
		bus_rd && !bus_rd_byte && bus_addr == I_LOWER_ADDR && !i_fault;
	endsequence

	sequence s_repl_d;
		bus_wr && bus_addr == D_LOWER_ADDR && !bus_rd && !d_fault;
	endsequence

	sequence s_look_d;
		bus_rd && !bus_rd_byte && bus_addr == D_LOWER_ADDR && !d_fault;
	endsequence

	a_fault_load_upper: assert property ( //RQ1
		i_fault |=> upper_reg[0] == {$past(i_fault_addr[31:10]), 2'b00, $past(cur_process_tag)})
		else $error("fault did not load the upper register");

	a_upper_rsvd_zero: assert property ( //RQ3
		bus_rd && !bus_rd_byte && bus_addr == D_UPPER_ADDR |=> bus_rdata[9:8] == 2'b00)
		else $error("reserved upper bits read nonzero");

	a_misaligned_write_drop: assert property ( //RQ5
		bus_wr && bus_addr[31:2] == I_UPPER_ADDR[31:2] && bus_addr[1:0] != 2'b00 && !i_fault
		|=> $stable(upper_reg[0]))
		else $error("misaligned write changed the upper register");

	a_byte_read_lane: assert property ( //RQ5
		bus_rd && bus_rd_byte && bus_addr == I_UPPER_ADDR + 32'h00000001
		|=> bus_rdata == {24'h000000, $past(upper_reg[0][15:8])})
		else $error("byte read returned the wrong lane");

	a_repl_then_hit: assert property ( //RQ6 RQ7 RQ20
		s_repl_i ##1 s_look_i |=> bus_rdata[0] && i_lookup_hit)
		else $error("replaced entry did not hit on lookup");

	a_prot_user_write: assert property ( //RQ12 RQ13
		$rose(i_user_wr) |-> $past(look_word[0][8:6]) == PROT_ALL_RW)
		else $error("user write granted without full protection code");

	a_cache_gate_off: assert property ( //RQ17 RQ18
		bus_rd && bus_addr[31:2] == D_LOWER_ADDR[31:2] && !cacheable_bit_enable
		|=> d_page_cacheable == (!$past(space_su1) && $past(cache_ctrl_on)))
		else $error("cacheable output ignored the disabled enable");

	a_sides_independent: assert property ( //RQ22
		bus_wr && bus_addr == D_LOWER_ADDR |=> $stable(lower_reg[0]) && $stable(hit_reg[0]))
		else $error("data side write disturbed instruction side");

	a_miss_clears_valid: assert property ( //RQ20
		s_look_i ##0 !g_side[0].st_hit |=> !bus_rdata[0] && !i_lookup_hit)
		else $error("miss returned a valid entry");

	a_rdata_idle_zero: assert property ( //RQ5
		!bus_rd |=> bus_rdata == 32'h00000000)
		else $error("read data did not fall back to zero");

	a_data_fault_load: assert property ( //RQ1 RQ22
		d_fault |=> upper_reg[1] ==
			{$past(d_fault_addr[31:10]), 2'b00, $past(cur_process_tag)})
		else $error("data fault did not load the upper register");

	a_upper_write_fields: assert property ( //RQ2 RQ3 RQ4
		bus_wr && bus_addr == I_UPPER_ADDR && !i_fault
		|=> upper_reg[0][VPN_MSB:VPN_LSB] == $past(bus_wdata[VPN_MSB:VPN_LSB])
			&& upper_reg[0][RSVD_MSB:RSVD_LSB] == 2'b00
			&& upper_reg[0][TAG_MSB:TAG_LSB] == $past(bus_wdata[TAG_MSB:TAG_LSB]))
		else $error("upper write stored the wrong fields");

	a_data_upper_write: assert property ( //RQ2 RQ4 RQ22
		bus_wr && bus_addr == D_UPPER_ADDR && !d_fault
		|=> upper_reg[1][VPN_MSB:VPN_LSB] == $past(bus_wdata[VPN_MSB:VPN_LSB])
			&& upper_reg[1][TAG_MSB:TAG_LSB] == $past(bus_wdata[TAG_MSB:TAG_LSB]))
		else $error("data upper write stored the wrong fields");

	a_lower_write_store: assert property ( //RQ6 RQ8 RQ14 RQ15 RQ19 RQ21
		s_repl_i |=> lower_reg[0] == $past(bus_wdata))
		else $error("lower write did not keep the written word");

	a_lower_read_match: assert property ( //RQ7
		s_look_i |=> bus_rdata == lower_reg[0])
		else $error("lower read data differs from the lower register");

	a_hit_sets_valid: assert property ( //RQ20
		s_look_i ##0 g_side[0].st_hit |=> bus_rdata[0] && i_lookup_hit)
		else $error("hit returned an invalid entry");

	a_full_prot_grant: assert property ( //RQ12
		s_look_i ##0 g_side[0].st_hit && look_word[0][PROT_MSB:PROT_LSB] == PROT_ALL_RW
		|=> i_priv_rd && i_priv_wr && i_user_rd && i_user_wr && !i_prot_bad)
		else $error("full protection code did not grant every access");

	a_prot_prohibited_flag: assert property ( //RQ13
		s_look_i ##0 look_word[0][PROT_LSB]
			&& look_word[0][PROT_MSB:PROT_LSB] != PROT_ALL_RW
		|=> i_prot_bad && !i_priv_rd && !i_user_wr)
		else $error("prohibited protection code not flagged");

	a_cache_gate_on: assert property ( //RQ16 RQ17
		bus_rd && bus_addr[31:2] == D_LOWER_ADDR[31:2] && cacheable_bit_enable
		|=> d_page_cacheable == $past(look_word[1][CACHE_BIT]))
		else $error("cacheable output ignored the page bit");

	a_second_space_uncached: assert property ( //RQ18
		bus_rd && bus_addr[31:2] == D_LOWER_ADDR[31:2]
			&& !cacheable_bit_enable && space_su1
		|=> !d_page_cacheable)
		else $error("second space was cached with the enable off");

	a_outputs_hold_idle: assert property ( //RQ7 RQ22
		!(bus_rd && bus_addr[31:2] == I_LOWER_ADDR[31:2])
		|=> $stable(i_lookup_hit) && $stable(i_page_cacheable) && $stable(i_prot_bad))
		else $error("instruction outputs moved without a lower read");

	a_data_repl_hit: assert property ( //RQ6 RQ7 RQ22
		s_repl_d ##1 s_look_d |=> bus_rdata[0] && d_lookup_hit)
		else $error("replaced data entry did not hit on lookup");

	a_data_miss_invalid: assert property ( //RQ20 RQ22
		s_look_d ##0 !g_side[1].st_hit |=> !bus_rdata[0] && !d_lookup_hit)
		else $error("data miss returned a valid entry");

endmodule : tea_regs

// ==== sim/tea_regs_tb.sv ====
// Self-checking bench for the instruction and data entry registers.
// Assumes the one-cycle strobe register port and one-cycle fault pulses.
`timescale 1ns/1ps

module tea_regs_tb import tea_pkg::*; ;
	logic        core_clk, rstn, bus_wr, bus_rd, bus_rd_byte;
	logic [31:0] bus_addr, bus_wdata, bus_rdata, i_fault_addr, d_fault_addr;
	logic        i_fault, d_fault, cbe, ctrl_on, su1;
	logic [7:0]  cur_tag;
	logic        i_hit, i_cach, i_prd, i_pwr, i_urd, i_uwr, i_bad;
	logic        d_hit, d_cach, d_prd, d_pwr, d_urd, d_uwr, d_bad;
	int          err_count, check_count;
	// Each row writes an entry, then probes with a second upper value, in row 0 the same one.
	logic [31:0] t_up [8] = '{32'h20000405, 32'h50000405, 32'h12345405, 32'h40000005,
		32'h60000005, 32'h80000005, 32'h70000409, 32'h71000405};
	logic [31:0] t_lo [8] = '{32'h11111801, 32'h11111801, 32'habcde1fd, 32'h22222401,
		32'h22222401, 32'h33333c01, 32'h44444201, 32'h44444001};
	logic [31:0] t_pr [8] = '{32'h20000405, 32'h50000005, 32'h12345c05, 32'h4001fc05,
		32'h60020005, 32'h803ffc05, 32'h70000422, 32'h71000406};
	logic        t_hit [8] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	// Bits are privileged read, privileged write, user read, user write, prohibited.
	logic [4:0]  p_exp [8] = '{5'h10, 5'h01, 5'h14, 5'h01, 5'h18, 5'h01, 5'h1c, 5'h1e};
	logic [31:0] lo;

	tea_regs dut (.core_clk(core_clk), .rstn(rstn), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rd_byte(bus_rd_byte), .bus_rdata(bus_rdata), .i_fault(i_fault),
		.i_fault_addr(i_fault_addr), .d_fault(d_fault), .d_fault_addr(d_fault_addr),
		.cur_process_tag(cur_tag), .cacheable_bit_enable(cbe), .cache_ctrl_on(ctrl_on),
		.space_su1(su1), .i_lookup_hit(i_hit), .i_page_cacheable(i_cach),
		.i_priv_rd(i_prd), .i_priv_wr(i_pwr), .i_user_rd(i_urd), .i_user_wr(i_uwr),
		.i_prot_bad(i_bad), .d_lookup_hit(d_hit), .d_page_cacheable(d_cach),
		.d_priv_rd(d_prd), .d_priv_wr(d_pwr), .d_user_rd(d_urd), .d_user_wr(d_uwr),
		.d_prot_bad(d_bad));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// Called right after an edge. The strobe stays up so writes run back to back;
	// every sequence of writes ends in a read, which lowers it.
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge core_clk);
	endtask : wr

	// Read data stand only in the cycle after the taking edge, so look mid-cycle.
	task automatic rd(input logic [31:0] a, input logic b, input logic [31:0] e, input string n);
		bus_addr <= a;
		bus_rd_byte <= b;
		bus_wr <= 1'b0;
		bus_rd <= 1'b1;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		bus_rd_byte <= 1'b0;
		@(negedge core_clk);
		check(n, e, bus_rdata);
		@(posedge core_clk);
	endtask : rd

	task automatic fault(input logic side, input logic [31:0] a, input logic [7:0] t);
		cur_tag <= t;
		i_fault_addr <= a;
		d_fault_addr <= a;
		i_fault <= !side;
		d_fault <= side;
		@(posedge core_clk);
		i_fault <= 1'b0;
		d_fault <= 1'b0;
	endtask : fault

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		print_verdict();
	end

	initial begin
		{rstn, bus_wr, bus_rd, bus_rd_byte, i_fault, d_fault, cbe, ctrl_on, su1} = '0;
		{bus_addr, bus_wdata, i_fault_addr, d_fault_addr, cur_tag} = '0;
		err_count = 0;
		check_count = 0;
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(I_UPPER_ADDR, 1'b0, 32'h0, "i upper");
		rd(D_UPPER_ADDR, 1'b0, 32'h0, "d upper");
		rd(I_LOWER_ADDR, 1'b0, 32'h0, "i lower");
		check("i hit", 32'h0, i_hit);
		rd(32'hc00000a8, 1'b0, 32'h0, "unmapped");
		$display("test reset finished");

		wr(I_UPPER_ADDR, 32'hfffffcff);
		rd(I_UPPER_ADDR, 1'b0, 32'hfffffcff, "i upper");
		fault(1'b0, 32'hdeadbf00, 8'h3c);
		rd(I_UPPER_ADDR, 1'b0, 32'hdeadbc3c, "i upper");
		rd(D_UPPER_ADDR, 1'b0, 32'h0, "d upper");
		fault(1'b1, 32'h0000ff00, 8'h81);
		rd(D_UPPER_ADDR, 1'b0, 32'h0000fc81, "d upper");
		wr(32'hc00000a5, 32'h12345678);
		for (int k = 0; k < 4; k++)
			rd(I_UPPER_ADDR + k, 1'b1, {24'h0, 8'(32'hdeadbc3c >> (8 * k))}, "byte");
		rd(I_UPPER_ADDR, 1'b0, 32'hdeadbc3c, "i upper");
		$display("test upper finished");

		for (int r = 0; r < 8; r++) begin
			wr(I_UPPER_ADDR, t_up[r]);
			wr(I_LOWER_ADDR, t_lo[r]);
			wr(I_UPPER_ADDR, t_pr[r]);
			lo = t_hit[r] ? t_lo[r] : {t_lo[r][31:1], 1'b0};
			rd(I_LOWER_ADDR, 1'b0, lo, "i lower");
			check("i hit", t_hit[r], i_hit);
		end
		$display("test lookup finished");

		for (int c = 0; c < 8; c++) begin
			wr(I_UPPER_ADDR, 32'h90000005 + (c << 12));
			wr(I_LOWER_ADDR, 32'h55555001 | (c << 6));
			rd(I_LOWER_ADDR, 1'b0, 32'h55555001 | (c << 6), "i lower");
			check("prot bad", p_exp[c][0], i_bad);
			if (!p_exp[c][0])
				check("perms", p_exp[c][4:1], {i_prd, i_pwr, i_urd, i_uwr});
		end
		$display("test protection finished");

		wr(D_UPPER_ADDR, 32'h12345405);
		rd(D_LOWER_ADDR, 1'b0, 32'h0, "d lower");
		check("d hit", 32'h0, d_hit);
		for (int e = 0; e < 2; e++) begin
			lo = e ? 32'h66666011 : 32'h66666039;
			wr(D_UPPER_ADDR, 32'h12345405 + (e << 12));
			wr(D_LOWER_ADDR, lo);
			for (int k = 0; k < 8; k++) begin
				cbe <= k[2];
				ctrl_on <= k[1];
				su1 <= k[0];
				rd(D_LOWER_ADDR, 1'b0, lo, "d lower");
				check("d cach", k[2] ? !e : (!k[0] && k[1]), d_cach);
				check("d perms", 32'h10, {d_prd, d_pwr, d_urd, d_uwr, d_bad});
			end
		end
		wr(I_UPPER_ADDR, 32'h12345c05);
		rd(I_LOWER_ADDR, 1'b0, 32'habcde1fd, "i lower");
		check("i cach", 32'h1, i_cach);
		$display("test cacheable finished");
		print_verdict();
	end
endmodule : tea_regs_tb
